// file: scaler_fmt_defs.svh
// What this block does
// - request mode: source sends only on request
// - enable set: input is continuous stream
// - source select routes decoder, port, raw
// - select 3 takes 16-bit YC if 8-bit out
// - hold bit: F/V update at line start
// - polarity bit inverts V code and gate
// - format bit picks 4:2:2 or 4:1:1
// - chroma every 1st to 4th line
// - vertical edge bit picks reference edge
// - vertical type: frame sync, both edges
// - field id is H level, optionally inverted
// - field edge bit picks field detect edge
// - clock select ignores or needs qualifier
// - qualifier polarity defines valid level
// - horizontal edge bit picks H edge
// - code bit takes references from SAV/EAV
// - luma skip drops leading luma lines
// - width bit: byte or 16-bit output
// - code bit inserts SAV/EAV in output
// - two register sets, active task's applies
// - leading-line count of zero to three
// - task end passes set unless repeat once
`ifndef SCALER_FMT_DEFS_SVH
`define SCALER_FMT_DEFS_SVH

// ****************************************************
// register indexes, byte address is four times these
// ****************************************************
`define IDX_INPUT_A   10'h091
`define IDX_REF_A     10'h092
`define IDX_OUTPUT_A  10'h093
`define IDX_INPUT_B   10'h0c1
`define IDX_REF_B     10'h0c2
`define IDX_OUTPUT_B  10'h0c3
`define IDX_STATUS    10'h040
`define CFG_RESET     8'h00

// ****************************************************
// field positions
// ****************************************************
`define B_VPOL        7
`define B_HOLDFV      6
`define B_SRC_HI      5
`define B_SRC_LO      4
`define B_SRQE        3
`define B_RATE_HI     2
`define B_RATE_LO     1
`define B_SCHEME      0
`define B_FEDGE       7
`define B_FINV        6
`define B_VTYPE       5
`define B_VEDGE       4
`define B_OUTPUT_CODE_ENABLE       3
`define B_HEDGE       2
`define B_QPOL        1
`define B_CKSEL       0
`define B_OCODE       7
`define B_OWIDTH      6
`define B_LSKIP       5
`define B_LEAD_HI     4
`define B_LEAD_LO     3

// ****************************************************
// stream constants
// ****************************************************
`define CHROMA_BLANK  8'h80
`define CODE_FF       8'hff
`define CODE_00       8'h00
`define VGATE_LINES   8'h14
`define CODE_LAST     3'h7
`define RESP_OKAY     2'b00
`define RESP_DECERR   2'b11

`endif

// file: scaler_fmt_pkg.sv
package scaler_fmt_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_CODE  = 3'b010,
    ST_BYTE2 = 3'b100
  } fmt_state_e;
  typedef logic [1:0] src_sel_t;
endpackage

// file: scaler_port_format_config.sv
`timescale 1ns/1ps
`include "scaler_fmt_defs.svh"
module scaler_port_format_config
  import scaler_fmt_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              SYS_CLK_IN,
  input  wire logic              RST_IN,
  input  wire logic              CE_IN,
  input  wire logic [ADDR_W-1:0] AXI_AWADDR_IN,
  input  wire logic              AXI_AWVALID_IN,
  output logic                   AXI_AWREADY_OUT,
  input  wire logic [31:0]       AXI_WDATA_IN,
  input  wire logic [3:0]        AXI_WSTRB_IN,
  input  wire logic              AXI_WVALID_IN,
  output logic                   AXI_WREADY_OUT,
  output logic [1:0]             AXI_BRESP_OUT,
  output logic                   AXI_BVALID_OUT,
  input  wire logic              AXI_BREADY_IN,
  input  wire logic [ADDR_W-1:0] AXI_ARADDR_IN,
  input  wire logic              AXI_ARVALID_IN,
  output logic                   AXI_ARREADY_OUT,
  output logic [31:0]            AXI_RDATA_OUT,
  output logic [1:0]             AXI_RRESP_OUT,
  output logic                   AXI_RVALID_OUT,
  input  wire logic              AXI_RREADY_IN,
  input  wire logic              PORT_CLOCK_IN,
  input  wire logic [15:0]       PORT_DATA_IN,
  input  wire logic              INPUT_QUALIFIER_IN,
  input  wire logic              EXT_HORIZONTAL_REF_IN,
  input  wire logic              EXT_VERTICAL_REF_IN,
  input  wire logic [15:0]       DECODER_DATA_IN,
  input  wire logic              DECODER_VALID_IN,
  input  wire logic              DECODER_VERTICAL_IN,
  input  wire logic              DECODER_FIELD_IN,
  input  wire logic [7:0]        RAW_CVBS_IN,
  input  wire logic              RAW_VALID_IN,
  input  wire logic              EXTERNAL_REQUEST_MODE_IN,
  input  wire logic              TASK_DONE_IN,
  input  wire logic              REPEAT_ONCE_IN,
  output logic                   SOURCE_REQUEST_OUT,
  output logic [7:0]             OUTPUT_BUS_LOW_OUT,
  output logic [7:0]             OUTPUT_BUS_HIGH_OUT,
  output logic                   OUTPUT_VALID_OUT,
  output logic                   OUTPUT_QUALIFIER_OUT,
  output logic                   VERTICAL_GATE_OUT,
  output logic                   FIELD_ID_OUT,
  output logic                   ACTIVE_SET_OUT
);

  if (ADDR_W < 12) begin : g_chk
    $error("ADDR_W must be at least 12");
  end

  // ****************************************************
  // register file
  // ****************************************************
  logic [7:0] in_a_q, ref_a_q, out_a_q, in_b_q, ref_b_q, out_b_q;
  logic       aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic [9:0] aw_idx_q;
  logic [7:0] wbyte_q;
  logic       wlane_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [9:0] ar_idx;
  logic [7:0] status;
  logic       do_write, wr_hit;

  assign AXI_AWREADY_OUT = CE_IN & ~aw_full_q & ~bvalid_q;
  assign AXI_WREADY_OUT  = CE_IN & ~w_full_q & ~bvalid_q;
  assign AXI_ARREADY_OUT = CE_IN & ~rvalid_q;
  assign AXI_BVALID_OUT  = bvalid_q;
  assign AXI_BRESP_OUT   = bresp_q;
  assign AXI_RVALID_OUT  = rvalid_q;
  assign AXI_RRESP_OUT   = rresp_q;
  assign AXI_RDATA_OUT   = rdata_q;
  assign do_write = aw_full_q & w_full_q & ~bvalid_q;
  assign ar_idx   = AXI_ARADDR_IN[11:2];
  assign wr_hit   = aw_idx_q == `IDX_INPUT_A || aw_idx_q == `IDX_REF_A ||
                    aw_idx_q == `IDX_OUTPUT_A || aw_idx_q == `IDX_INPUT_B ||
                    aw_idx_q == `IDX_REF_B || aw_idx_q == `IDX_OUTPUT_B;

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
      aw_idx_q  <= 10'h000;
      wbyte_q   <= 8'h00;
      wlane_q   <= 1'b0;
    end else if (CE_IN) begin
      if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
        aw_full_q <= 1'b1;
        aw_idx_q  <= AXI_AWADDR_IN[11:2];
      end
      if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
        w_full_q <= 1'b1;
        wbyte_q  <= AXI_WDATA_IN[7:0];
        wlane_q  <= AXI_WSTRB_IN[0];
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (wr_hit || aw_idx_q == `IDX_STATUS) ?
                     `RESP_OKAY : `RESP_DECERR;
      end else if (bvalid_q && AXI_BREADY_IN) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      in_a_q  <= `CFG_RESET;
      ref_a_q <= `CFG_RESET;
      out_a_q <= `CFG_RESET;
      in_b_q  <= `CFG_RESET;
      ref_b_q <= `CFG_RESET;
      out_b_q <= `CFG_RESET;
    end else if (CE_IN && do_write && wlane_q) begin
      case (aw_idx_q)
        `IDX_INPUT_A:  in_a_q  <= wbyte_q;
        `IDX_REF_A:    ref_a_q <= wbyte_q;
        `IDX_OUTPUT_A: out_a_q <= wbyte_q;
        `IDX_INPUT_B:  in_b_q  <= wbyte_q;
        `IDX_REF_B:    ref_b_q <= wbyte_q;
        `IDX_OUTPUT_B: out_b_q <= wbyte_q;
        default: ;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      rvalid_q <= 1'b0;
      rresp_q  <= `RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (CE_IN) begin
      if (AXI_ARVALID_IN && AXI_ARREADY_OUT) begin
        rvalid_q <= 1'b1;
        rresp_q  <= `RESP_OKAY;
        case (ar_idx)
          `IDX_INPUT_A:  rdata_q <= {24'h000000, in_a_q};
          `IDX_REF_A:    rdata_q <= {24'h000000, ref_a_q};
          `IDX_OUTPUT_A: rdata_q <= {24'h000000, out_a_q};
          `IDX_INPUT_B:  rdata_q <= {24'h000000, in_b_q};
          `IDX_REF_B:    rdata_q <= {24'h000000, ref_b_q};
          `IDX_OUTPUT_B: rdata_q <= {24'h000000, out_b_q};
          `IDX_STATUS:   rdata_q <= {24'h000000, status};
          default: begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= `RESP_DECERR;
          end
        endcase
      end else if (rvalid_q && AXI_RREADY_IN) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ****************************************************
  // task sequencing and active set
  // ****************************************************
  logic set_b_q, repeated_q;

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      set_b_q    <= 1'b0;
      repeated_q <= 1'b0;
    end else if (CE_IN && TASK_DONE_IN) begin
      if (REPEAT_ONCE_IN && !repeated_q) begin
        repeated_q <= 1'b1;
      end else begin
        set_b_q    <= ~set_b_q;
        repeated_q <= 1'b0;
      end
    end
  end

  logic [7:0] cfg_in, cfg_ref, cfg_out;
  src_sel_t   src;
  assign cfg_in  = set_b_q ? in_b_q  : in_a_q;
  assign cfg_ref = set_b_q ? ref_b_q : ref_a_q;
  assign cfg_out = set_b_q ? out_b_q : out_a_q;
  assign src     = {cfg_in[`B_SRC_HI], cfg_in[`B_SRC_LO]};
  assign ACTIVE_SET_OUT = set_b_q;

  // ****************************************************
  // expansion port synchroniser
  // ****************************************************
  // a 200 ns port clock against 25 ns sampling leaves data stable
  // for several sys cycles around each detected edge
  logic [19:0] meta_q, sync_q;
  logic [2:0]  prev_q;
  logic        p_clk, p_qual, p_h, p_v;
  logic [15:0] p_data;
  // two-flop capture, one sample per edge
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      meta_q <= 20'h00000;
      sync_q <= 20'h00000;
      prev_q <= 3'h0;
    end else if (CE_IN) begin
      meta_q <= {PORT_CLOCK_IN, INPUT_QUALIFIER_IN, EXT_HORIZONTAL_REF_IN,
                 EXT_VERTICAL_REF_IN, PORT_DATA_IN};
      sync_q <= meta_q;
      prev_q <= {sync_q[19], sync_q[17], sync_q[16]};
    end
  end
  assign {p_clk, p_qual, p_h, p_v, p_data} = sync_q;

  logic pclk_rise, h_rise, h_fall, xv_rise, xv_fall, qual_ok, port_smp;
  assign pclk_rise = p_clk & ~prev_q[2];
  assign h_rise    = p_h & ~prev_q[1];
  assign h_fall    = ~p_h & prev_q[1];
  assign xv_rise   = p_v & ~prev_q[0];
  assign xv_fall   = ~p_v & prev_q[0];
  assign qual_ok  = cfg_ref[`B_CKSEL] | (p_qual ^ cfg_ref[`B_QPOL]);
  assign port_smp = pclk_rise & qual_ok;

  // ****************************************************
  // source selection and request
  // ****************************************************
  logic        req_mode, src_valid, accept, pend_q, owidth;
  logic [15:0] src_word, pend_word_q;
  assign owidth = cfg_out[`B_OWIDTH];
  // request mode when enable is clear and EXTERNAL_REQUEST_MODE_IN is high
  assign req_mode = ~cfg_in[`B_SRQE] & EXTERNAL_REQUEST_MODE_IN;
  assign SOURCE_REQUEST_OUT = req_mode & ~pend_q;

  always_comb begin
    src_valid = 1'b0;
    src_word  = 16'h0000;
    case (src)
      2'b00: begin
        src_valid = DECODER_VALID_IN;
        src_word  = DECODER_DATA_IN;
      end
      2'b01: begin
        src_valid = port_smp;
        src_word  = p_data;
      end
      2'b10: begin
        src_valid = RAW_VALID_IN;
        src_word  = {RAW_CVBS_IN, `CHROMA_BLANK};
      end
      default: begin
        src_valid = port_smp;
        src_word  = owidth ? {p_data[7:0], `CHROMA_BLANK} : p_data;
      end
    endcase
  end
  assign accept = src_valid & (~req_mode | ~pend_q);

  // ****************************************************
  // references: embedded codes, edges, field
  // ****************************************************
  logic [23:0] hist_q;
  logic        code_v_q, code_f_q, sav_evt, code_hit, in_code;
  logic        vsrc, vsrc_prev_q, v_rise, v_fall, h_evt, v_evt;
  logic        field_raw_q, field_id, fedge;
  assign in_code  = cfg_ref[`B_OUTPUT_CODE_ENABLE];
  assign code_hit = port_smp &&
                    hist_q == {`CODE_FF, `CODE_00, `CODE_00};
  assign sav_evt  = code_hit & ~p_data[4];

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      hist_q   <= 24'h000000;
      code_v_q <= 1'b0;
      code_f_q <= 1'b0;
    end else if (CE_IN && port_smp) begin
      hist_q <= {hist_q[15:0], p_data[7:0]};
      if (code_hit) begin
        code_f_q <= p_data[6];
        code_v_q <= p_data[5];
      end
    end
  end

  assign vsrc = (src == 2'b00) ? DECODER_VERTICAL_IN :
                in_code ? code_v_q : p_v;
  assign v_rise = vsrc & ~vsrc_prev_q;
  assign v_fall = ~vsrc & vsrc_prev_q;
  assign h_evt = in_code ? sav_evt :
                 (cfg_ref[`B_HEDGE] ? h_fall : h_rise);
  // frame sync pulses on both edges
  assign v_evt = cfg_ref[`B_VTYPE] ? (v_rise | v_fall) :
                 (cfg_ref[`B_VEDGE] ? v_fall : v_rise);
  assign fedge = cfg_ref[`B_FEDGE] ? xv_rise : xv_fall;

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      vsrc_prev_q <= 1'b0;
      field_raw_q <= 1'b0;
    end else if (CE_IN) begin
      vsrc_prev_q <= vsrc;
      // field is H level at edge
      if (in_code) begin
        field_raw_q <= code_f_q;
      end else if (fedge) begin
        field_raw_q <= p_h;
      end
    end
  end
  assign field_id = ((src == 2'b00) ? DECODER_FIELD_IN : field_raw_q)
                    ^ cfg_ref[`B_FINV];

  // ****************************************************
  // line counting, chroma rate, luma skip
  // ****************************************************
  logic [7:0] line_q;
  logic [1:0] chroma_cnt_q, rate, lead;
  logic       phase_q, chroma_ok, skip_line, vgate;
  assign rate = {cfg_in[`B_RATE_HI], cfg_in[`B_RATE_LO]};
  assign lead = {cfg_out[`B_LEAD_HI], cfg_out[`B_LEAD_LO]};
  assign vgate = line_q < `VGATE_LINES;

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      line_q       <= 8'h00;
      chroma_cnt_q <= 2'b00;
      phase_q      <= 1'b0;
    end else if (CE_IN) begin
      if (v_evt) begin
        line_q       <= 8'h00;
        chroma_cnt_q <= 2'b00;
        phase_q      <= 1'b0;
      end else if (h_evt) begin
        if (line_q != 8'hff) begin
          line_q <= line_q + 8'h01;
        end
        chroma_cnt_q <= (chroma_cnt_q >= rate) ? 2'b00 :
                        chroma_cnt_q + 2'b01;
        phase_q <= 1'b0;
      end else if (accept) begin
        phase_q <= ~phase_q;
      end
    end
  end
  // 4:1:1 carries chroma every second sample
  assign chroma_ok = (chroma_cnt_q == 2'b00) &
                     (~cfg_in[`B_SCHEME] | ~phase_q);
  assign skip_line = cfg_out[`B_LSKIP] & (line_q < {6'h00, lead});

  // ****************************************************
  // F/V bits and vertical gate
  // ****************************************************
  logic held_f_q, held_v_q, live_v, code_f, code_v, vgate_q, fid_q;
  // polarity on V code bit and gate
  assign live_v = vgate ^ cfg_in[`B_VPOL];
  assign code_f = cfg_in[`B_HOLDFV] ? held_f_q : field_id;
  assign code_v = cfg_in[`B_HOLDFV] ? held_v_q : live_v;

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      held_f_q <= 1'b0;
      held_v_q <= 1'b0;
      vgate_q  <= 1'b0;
      fid_q    <= 1'b0;
    end else if (CE_IN) begin
      if (h_evt) begin
        held_f_q <= field_id;
        held_v_q <= live_v;
      end
      vgate_q <= live_v;
      fid_q   <= field_id;
    end
  end
  assign VERTICAL_GATE_OUT = vgate_q;
  assign FIELD_ID_OUT      = fid_q;
  assign status = {4'h0, ~pend_q, vgate_q, fid_q, set_b_q};

  function automatic logic [7:0] code_xy(input logic f, input logic v,
                                         input logic h);
    code_xy = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
  endfunction

  // ****************************************************
  // output formatter
  // ****************************************************
  fmt_state_e  state_q;
  logic [2:0]  code_idx_q;
  logic [7:0]  lo_q, hi_q, chroma_q, code_byte;
  logic        ovalid_q, oqual_q;

  always_comb begin
    case (code_idx_q)
      3'h0, 3'h4: code_byte = `CODE_FF;
      3'h3:       code_byte = code_xy(code_f, code_v, 1'b1);
      3'h7:       code_byte = code_xy(code_f, code_v, 1'b0);
      default:    code_byte = `CODE_00;
    endcase
  end

  // single holding slot absorbs a sample that lands during code insertion
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      pend_q      <= 1'b0;
      pend_word_q <= 16'h0000;
    end else if (CE_IN) begin
      if (accept && !skip_line) begin
        pend_q      <= 1'b1;
        pend_word_q <= {src_word[15:8],
                        chroma_ok ? src_word[7:0] : `CHROMA_BLANK};
      end else if (state_q == ST_IDLE && !(h_evt && cfg_out[`B_OCODE])) begin
        pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      state_q    <= ST_IDLE;
      code_idx_q <= 3'h0;
      lo_q       <= 8'h00;
      hi_q       <= 8'h00;
      chroma_q   <= 8'h00;
      ovalid_q   <= 1'b0;
      oqual_q    <= 1'b0;
    end else if (CE_IN) begin
      ovalid_q <= 1'b0;
      oqual_q  <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (h_evt && cfg_out[`B_OCODE]) begin
            code_idx_q <= 3'h0;
            state_q    <= ST_CODE;
          end else if (pend_q) begin
            lo_q     <= pend_word_q[15:8];
            ovalid_q <= 1'b1;
            oqual_q  <= 1'b1;
            if (owidth) begin
              hi_q <= pend_word_q[7:0];
            end else begin
              chroma_q <= pend_word_q[7:0];
              state_q  <= ST_BYTE2;
            end
          end
        end
        ST_CODE: begin
          lo_q       <= code_byte;
          hi_q       <= owidth ? code_byte : 8'h00;
          ovalid_q   <= 1'b1;
          code_idx_q <= code_idx_q + 3'h1;
          if (code_idx_q == `CODE_LAST) begin
            state_q <= ST_IDLE;
          end
        end
        ST_BYTE2: begin
          lo_q     <= chroma_q;
          ovalid_q <= 1'b1;
          oqual_q  <= 1'b1;
          state_q  <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign OUTPUT_BUS_LOW_OUT   = lo_q;
  assign OUTPUT_BUS_HIGH_OUT  = hi_q;
  assign OUTPUT_VALID_OUT     = ovalid_q;
  assign OUTPUT_QUALIFIER_OUT = oqual_q;

endmodule

// file: scaler_fmt_asserts.sv
`timescale 1ns/1ps
// ****************************************************
// port checker
// ****************************************************
module scaler_fmt_asserts (
  input wire logic        SYS_CLK_IN,
  input wire logic        RST_IN,
  input wire logic        AXI_AWREADY_OUT,
  input wire logic [1:0]  AXI_BRESP_OUT,
  input wire logic        AXI_BVALID_OUT,
  input wire logic        AXI_BREADY_IN,
  input wire logic        AXI_ARVALID_IN,
  input wire logic        AXI_ARREADY_OUT,
  input wire logic [31:0] AXI_RDATA_OUT,
  input wire logic        AXI_RVALID_OUT,
  input wire logic        AXI_RREADY_IN,
  input wire logic        EXTERNAL_REQUEST_MODE_IN,
  input wire logic        TASK_DONE_IN,
  input wire logic        REPEAT_ONCE_IN,
  input wire logic        SOURCE_REQUEST_OUT,
  input wire logic [7:0]  OUTPUT_BUS_LOW_OUT,
  input wire logic        OUTPUT_VALID_OUT,
  input wire logic        OUTPUT_QUALIFIER_OUT,
  input wire logic        VERTICAL_GATE_OUT,
  input wire logic        ACTIVE_SET_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);
  // code bytes carry no qualifier, so they are told apart from video
  sequence code_lead;
    OUTPUT_VALID_OUT && !OUTPUT_QUALIFIER_OUT && OUTPUT_BUS_LOW_OUT == 8'hff;
  endsequence
  sequence code_zeros;
    (OUTPUT_VALID_OUT && OUTPUT_BUS_LOW_OUT == 8'h00) [*2];
  endsequence
  b_hold_a: assert property (AXI_BVALID_OUT && !AXI_BREADY_IN |=>
    AXI_BVALID_OUT && $stable(AXI_BRESP_OUT)) else $error("bresp dropped");
  r_hold_a: assert property (AXI_RVALID_OUT && !AXI_RREADY_IN |=>
    AXI_RVALID_OUT && $stable(AXI_RDATA_OUT)) else $error("rdata dropped");
  read_answer_a: assert property (AXI_ARVALID_IN && AXI_ARREADY_OUT |=>
    AXI_RVALID_OUT && AXI_RDATA_OUT[31:8] == 24'h0) else $error("bad read");
  aw_block_a: assert property (AXI_BVALID_OUT |-> !AXI_AWREADY_OUT)
    else $error("aw ready while response pending");
  request_mode_a: assert property (SOURCE_REQUEST_OUT |->
    EXTERNAL_REQUEST_MODE_IN) else $error("request outside request mode");
  code_frame_a: assert property (code_lead |=> code_zeros)
    else $error("code preamble broken");
  qual_valid_a: assert property (OUTPUT_QUALIFIER_OUT |->
    OUTPUT_VALID_OUT) else $error("qualifier without valid");
  set_flip_a: assert property (TASK_DONE_IN && !REPEAT_ONCE_IN |=>
    ACTIVE_SET_OUT != $past(ACTIVE_SET_OUT)) else $error("set not switched");
  gate_start_a: assert property ($fell(RST_IN) |=> VERTICAL_GATE_OUT)
    else $error("vertical gate not set");
endmodule
bind scaler_port_format_config scaler_fmt_asserts chk (
  .SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN),
  .AXI_AWREADY_OUT(AXI_AWREADY_OUT), .AXI_BRESP_OUT(AXI_BRESP_OUT),
  .AXI_BVALID_OUT(AXI_BVALID_OUT), .AXI_BREADY_IN(AXI_BREADY_IN),
  .AXI_ARVALID_IN(AXI_ARVALID_IN), .AXI_ARREADY_OUT(AXI_ARREADY_OUT),
  .AXI_RDATA_OUT(AXI_RDATA_OUT), .AXI_RVALID_OUT(AXI_RVALID_OUT),
  .AXI_RREADY_IN(AXI_RREADY_IN),
  .EXTERNAL_REQUEST_MODE_IN(EXTERNAL_REQUEST_MODE_IN),
  .TASK_DONE_IN(TASK_DONE_IN), .REPEAT_ONCE_IN(REPEAT_ONCE_IN),
  .SOURCE_REQUEST_OUT(SOURCE_REQUEST_OUT),
  .OUTPUT_BUS_LOW_OUT(OUTPUT_BUS_LOW_OUT),
  .OUTPUT_VALID_OUT(OUTPUT_VALID_OUT),
  .OUTPUT_QUALIFIER_OUT(OUTPUT_QUALIFIER_OUT),
  .VERTICAL_GATE_OUT(VERTICAL_GATE_OUT), .ACTIVE_SET_OUT(ACTIVE_SET_OUT)
);

// file: video_source_model.sv
`timescale 1ns/1ps
// ****************************************************
// expansion port source
// ****************************************************
module video_source_model (
  output logic        port_clock_out,
  output logic [15:0] port_data_out,
  output logic        qualifier_out,
  output logic        h_ref_out,
  output logic        v_ref_out
);
  initial begin
    port_clock_out = 1'b0;
    port_data_out  = 16'h5aa5;
    qualifier_out  = 1'b0;
    h_ref_out      = 1'b0;
    v_ref_out      = 1'b0;
  end
  // clock stands still outside a line; data changes at the low phase
  task automatic send_line(input int n, input logic [7:0] y0,
                           input logic qpol);
    h_ref_out <= 1'b1;
    #400 h_ref_out <= 1'b0;
    #400;
    for (int i = 0; i < n; i++) begin
      port_data_out <= {y0 + 8'(i), 8'h40 + 8'(i)};
      qualifier_out <= ~qpol;
      #100 port_clock_out <= 1'b1;
      #100 port_clock_out <= 1'b0;
    end
    port_data_out <= ~port_data_out;
    qualifier_out <= qpol;
  endtask
endmodule

// file: testbench.sv
`timescale 1ns/1ps
`include "scaler_fmt_defs.svh"
module testbench;
  logic        clk, rst, awv, wv, arv, done, rpt, xreq, dval, word;
  logic        awr, wrdy, bval, arr, rval, sreq, ov, oq, vg, aset;
  logic        pclk, pq, href, vref, fid, bready, rready;
  logic [3:0]  strb;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat, d;
  logic [15:0] ddat, pdat;
  logic [1:0]  bresp, rresp, resp;
  logic [7:0]  lo, hi;
  logic [7:0]  got_q[$];
  logic [9:0]  idx[6];
  int          codes, num_errors, total_checks, cycles;

  scaler_port_format_config uut (
    .SYS_CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1), .AXI_AWADDR_IN(awa),
    .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awr), .AXI_WDATA_IN(wd),
    .AXI_WSTRB_IN(strb), .AXI_WVALID_IN(wv), .AXI_WREADY_OUT(wrdy),
    .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bval), .AXI_BREADY_IN(bready),
    .AXI_ARADDR_IN(ara), .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arr),
    .AXI_RDATA_OUT(rdat), .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rval),
    .AXI_RREADY_IN(rready), .PORT_CLOCK_IN(pclk), .PORT_DATA_IN(pdat),
    .INPUT_QUALIFIER_IN(pq), .EXT_HORIZONTAL_REF_IN(href),
    .EXT_VERTICAL_REF_IN(vref), .DECODER_DATA_IN(ddat),
    .DECODER_VALID_IN(dval), .DECODER_VERTICAL_IN(1'b0),
    .DECODER_FIELD_IN(1'b0), .RAW_CVBS_IN(8'h00), .RAW_VALID_IN(1'b0),
    .EXTERNAL_REQUEST_MODE_IN(xreq), .TASK_DONE_IN(done),
    .REPEAT_ONCE_IN(rpt), .SOURCE_REQUEST_OUT(sreq),
    .OUTPUT_BUS_LOW_OUT(lo), .OUTPUT_BUS_HIGH_OUT(hi),
    .OUTPUT_VALID_OUT(ov), .OUTPUT_QUALIFIER_OUT(oq),
    .VERTICAL_GATE_OUT(vg), .FIELD_ID_OUT(fid), .ACTIVE_SET_OUT(aset));
  video_source_model src (.port_clock_out(pclk), .port_data_out(pdat),
    .qualifier_out(pq), .h_ref_out(href), .v_ref_out(vref));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // word mode puts chroma on the high bus, so both land in one queue
  always @(posedge clk) begin
    cycles++;
    if (ov === 1'b1 && oq === 1'b1) begin
      got_q.push_back(lo);
      if (word) got_q.push_back(hi);
    end else if (ov === 1'b1) codes++;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  task stop_test();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task wr(input logic [9:0] i, input logic [31:0] v);
    logic ad, wdn;
    ad = 1'b0;
    wdn = 1'b0;
    awa <= {i, 2'b00};
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(ad && wdn)) begin
      @(posedge clk);
      if (awv && awr) begin ad = 1'b1; awv <= 1'b0; end
      if (wv && wrdy) begin wdn = 1'b1; wv <= 1'b0; end
    end
    do @(posedge clk); while (bval !== 1'b1);
    bready <= 1'b1;
    @(posedge clk);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [9:0] i);
    ara <= {i, 2'b00};
    arv <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rval !== 1'b1);
    rready <= 1'b1;
    @(posedge clk);
    d = rdat;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task pulse_done();
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task video(input logic [7:0] inp, input logic [7:0] rf,
             input logic [7:0] op, input logic qp, input int nc);
    wr(`IDX_INPUT_A, {24'h0, inp});
    wr(`IDX_REF_A, {24'h0, rf});
    wr(`IDX_OUTPUT_A, {24'h0, op});
    word = op[6];
    got_q.delete();
    codes = 0;
    src.send_line(4, 8'h20, qp);
    repeat (30) @(posedge clk);
    chk(got_q.size(), 8);
    for (int k = 0; k < 4; k++) begin
      chk(got_q[2*k], 8'h20 + k);
      chk(got_q[2*k+1], (inp[0] && k[0]) ? 8'h80 : 8'h40 + k);
    end
    chk(codes, nc);
    $display("video test %h %h %h done", inp, rf, op);
  endtask

  initial begin
    {rst, awv, wv, arv, done, rpt, xreq, dval, word, bready, rready} = 11'h400;
    {awa, ara, wd, ddat, codes, cycles} = '0;
    strb = 4'hf;
    {num_errors, total_checks} = '0;
    idx = '{`IDX_INPUT_A, `IDX_REF_A, `IDX_OUTPUT_A,
            `IDX_INPUT_B, `IDX_REF_B, `IDX_OUTPUT_B};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (idx[k]) begin rd(idx[k]); chk(d, 0); end
    foreach (idx[k]) wr(idx[k], 32'hdeadbe50 + k);
    foreach (idx[k]) begin rd(idx[k]); chk(d, 32'h50 + k); end
    // lane 0 strobe low must leave the register untouched
    strb <= 4'he;
    wr(`IDX_OUTPUT_B, 32'h1);
    strb <= 4'hf;
    rd(`IDX_OUTPUT_B);
    chk(d, 32'h55);
    rd(10'h3ff);
    chk({d[29:0], resp}, 2'b11);
    wr(10'h3ff, 32'h1);
    chk(resp, 2'b11);
    $display("register test done");
    pulse_done();
    chk(aset, 1);
    rd(`IDX_STATUS);
    chk(d[0], 1);
    rpt <= 1'b1;
    pulse_done();
    chk(aset, 1);
    pulse_done();
    chk(aset, 0);
    rpt <= 1'b0;
    wr(`IDX_INPUT_A, 32'h80);
    repeat (2) @(posedge clk);
    chk(vg, 0);
    xreq <= 1'b1;
    wr(`IDX_INPUT_A, 32'h0);
    repeat (2) @(posedge clk);
    chk({vg, sreq, fid}, 3'b111);
    wr(`IDX_INPUT_A, 32'h8);
    repeat (2) @(posedge clk);
    chk(sreq, 0);
    xreq <= 1'b0;
    $display("control test done");
    video(8'h18, 8'h00, 8'h40, 1'b0, 0);
    video(8'h18, 8'h00, 8'h80, 1'b0, 8);
    video(8'h18, 8'h02, 8'h40, 1'b1, 0);
    video(8'h18, 8'h01, 8'h40, 1'b1, 0);
    video(8'h19, 8'h00, 8'h40, 1'b0, 0);
    stop_test();
  end
endmodule
